// File: hw/vlm_monitor.sv
// Supply-rail level monitor, threshold alarms and drain control behind AXI4-Lite
`timescale 1ns/10ps
module vlm_monitor #(
    parameter int LEVEL_W = vlm_pkg::LEVEL_W
) (
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic [11:0]            s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [11:0]            s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire logic                   sample_valid,
    input  wire logic [LEVEL_W-1:0]     sample_level,
    input  wire logic [1:0]             sample_scale,
    input  wire logic                   supply_present_flag,
    output logic                        drain_en,
    output logic                        upper_alarm_flag,
    output logic                        lower_alarm_flag,
    output logic                        irq
);

    logic [7:0]                 read_lo_r;
    logic [7:0]                 read_hi_r;
    logic [LEVEL_W-1:0]         sink_detach_level_r;
    logic [LEVEL_W-1:0]         drain_stop_level_r;
    logic [LEVEL_W-1:0]         upper_alarm_level_r;
    logic [LEVEL_W-1:0]         lower_alarm_level_r;
    logic                       auto_drain_r;
    logic                       alarm_inhibit_r;
    logic                       source_role_r;
    logic [vlm_pkg::EV_W-1:0]   int_status_r;
    logic [vlm_pkg::EV_W-1:0]   int_enable_r;
    logic [vlm_pkg::EV_W-1:0]   ev_set;
    logic [vlm_pkg::EV_W-1:0]   ev_clr;
    logic                       detached_r;
    logic                       detach_cond;
    logic                       detach_prev_r;
    logic                       drain_done;
    logic                       drain_go;
    vlm_pkg::vlm_drain_t        drain_state_r;

    // Bus-side holding registers
    logic                       aw_held_r;
    logic                       w_held_r;
    logic [9:0]                 aw_idx_r;
    logic [31:0]                wdata_r;
    logic [3:0]                 wstrb_r;
    logic                       wr_fire;
    logic                       wr_byte;

    assign wr_fire = aw_held_r && w_held_r && !s_axi_bvalid;
    assign wr_byte = wr_fire && wstrb_r[0];

    function automatic logic idx_mapped(input logic [9:0] idx);
        idx_mapped = (idx >= vlm_pkg::IDX_READ_LO) && (idx <= vlm_pkg::IDX_INT_ENABLE);
    endfunction

    function automatic logic idx_writable(input logic [9:0] idx);
        idx_writable = (idx >= vlm_pkg::IDX_DETACH_LO) && (idx <= vlm_pkg::IDX_INT_ENABLE)
                       && (idx != vlm_pkg::IDX_STATE) && (idx != vlm_pkg::IDX_INT_STATUS);
    endfunction

    // Write-address and write-data channels are taken independently
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_r     <= 1'b0;
            aw_idx_r      <= 10'h000;
            s_axi_awready <= 1'b1;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_r     <= 1'b1;
            aw_idx_r      <= s_axi_awaddr[11:2];
            s_axi_awready <= 1'b0;
        end
        else if (wr_fire)
        begin
            aw_held_r     <= 1'b0;
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_held_r     <= 1'b0;
            wdata_r      <= 32'h0000_0000;
            wstrb_r      <= 4'h0;
            s_axi_wready <= 1'b1;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_r     <= 1'b1;
            wdata_r      <= s_axi_wdata;
            wstrb_r      <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end
        else if (wr_fire)
        begin
            w_held_r     <= 1'b0;
            s_axi_wready <= 1'b1;
        end
    end

    // Response only after both halves arrived; one write in flight
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= vlm_pkg::RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= idx_writable(aw_idx_r) ? vlm_pkg::RESP_OKAY : vlm_pkg::RESP_SLVERR;
        end
        else if (s_axi_bready)
        begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Threshold byte pairs; upper byte keeps only bits 9:8
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sink_detach_level_r <= vlm_pkg::LEVEL_RESET;
            drain_stop_level_r  <= vlm_pkg::LEVEL_RESET;
            upper_alarm_level_r <= vlm_pkg::LEVEL_RESET;
            lower_alarm_level_r <= vlm_pkg::LEVEL_RESET;
        end
        else if (wr_byte)
        begin
            case (aw_idx_r)
                vlm_pkg::IDX_DETACH_LO: sink_detach_level_r[7:0] <= wdata_r[7:0];
                vlm_pkg::IDX_DETACH_HI: sink_detach_level_r[9:8] <= wdata_r[1:0];
                vlm_pkg::IDX_STOP_LO:   drain_stop_level_r[7:0]  <= wdata_r[7:0];
                vlm_pkg::IDX_STOP_HI:   drain_stop_level_r[9:8]  <= wdata_r[1:0];
                vlm_pkg::IDX_UPPER_LO:  upper_alarm_level_r[7:0] <= wdata_r[7:0];
                vlm_pkg::IDX_UPPER_HI:  upper_alarm_level_r[9:8] <= wdata_r[1:0];
                vlm_pkg::IDX_LOWER_LO:  lower_alarm_level_r[7:0] <= wdata_r[7:0];
                vlm_pkg::IDX_LOWER_HI:  lower_alarm_level_r[9:8] <= wdata_r[1:0];
                default:                ;
            endcase
        end
    end

    // Control bits; the drain start bit is a pulse and never stored
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            auto_drain_r    <= 1'b0;
            alarm_inhibit_r <= 1'b0;
            source_role_r   <= 1'b0;
            int_enable_r    <= '0;
        end
        else if (wr_byte && aw_idx_r == vlm_pkg::IDX_CTRL)
        begin
            auto_drain_r    <= wdata_r[vlm_pkg::CTRL_AUTO_DRAIN];
            alarm_inhibit_r <= wdata_r[vlm_pkg::CTRL_INHIBIT];
            source_role_r   <= wdata_r[vlm_pkg::CTRL_SOURCE];
        end
        else if (wr_byte && aw_idx_r == vlm_pkg::IDX_INT_ENABLE)
        begin
            int_enable_r    <= wdata_r[vlm_pkg::EV_W-1:0];
        end
    end

    assign drain_go = wr_byte && aw_idx_r == vlm_pkg::IDX_CTRL && wdata_r[vlm_pkg::CTRL_DRAIN_GO];

    // Latest sample, split into the two reading bytes
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            read_lo_r <= vlm_pkg::REG_RESET;
            read_hi_r <= vlm_pkg::REG_RESET;
        end
        else if (sample_valid)
        begin
            read_lo_r <= sample_level[7:0];
            read_hi_r <= {4'h0, sample_scale, sample_level[9:8]};
        end
    end

    // Detach source: level below threshold, or presence flag when threshold is zero
    always_comb
    begin
        if (sink_detach_level_r != vlm_pkg::LEVEL_RESET)
            detach_cond = sample_level < sink_detach_level_r;
        else
            detach_cond = !supply_present_flag;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            detach_prev_r <= 1'b0;
            detached_r    <= 1'b0;
        end
        else if (sample_valid)
        begin
            detach_prev_r <= detach_cond;
            detached_r    <= detach_cond && !source_role_r;
        end
    end

    // Stop point depends on role; sink ignores the stop level
    always_comb
    begin
        case (drain_state_r)
            vlm_pkg::VLM_DRAIN_SINK:
                drain_done = sample_valid && sample_level <= vlm_pkg::SAFE0_LEVEL;
            vlm_pkg::VLM_DRAIN_SOURCE:
                if (drain_stop_level_r != vlm_pkg::LEVEL_RESET)
                    drain_done = sample_valid && sample_level <= drain_stop_level_r;
                else
                    drain_done = sample_valid && sample_level <= vlm_pkg::SAFE0_LEVEL;
            default:
                drain_done = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            drain_state_r <= vlm_pkg::VLM_IDLE;
            drain_en      <= 1'b0;
        end
        else
        begin
            case (drain_state_r)
                vlm_pkg::VLM_IDLE:
                    if (sample_valid && auto_drain_r && !source_role_r && detach_cond && !detach_prev_r)
                    begin
                        drain_state_r <= vlm_pkg::VLM_DRAIN_SINK;
                        drain_en      <= 1'b1;
                    end
                    else if (drain_go && source_role_r)
                    begin
                        drain_state_r <= vlm_pkg::VLM_DRAIN_SOURCE;
                        drain_en      <= 1'b1;
                    end
                vlm_pkg::VLM_DRAIN_SINK, vlm_pkg::VLM_DRAIN_SOURCE:
                    if (drain_done)
                    begin
                        drain_state_r <= vlm_pkg::VLM_IDLE;
                        drain_en      <= 1'b0;
                    end
                default:
                begin
                    drain_state_r <= vlm_pkg::VLM_IDLE;
                    drain_en      <= 1'b0;
                end
            endcase
        end
    end

    // Events from each new sample compared against full 10-bit levels
    always_comb
    begin
        ev_set                         = '0;
        ev_set[vlm_pkg::EV_UPPER]      = sample_valid && !alarm_inhibit_r
                                         && sample_level > upper_alarm_level_r;
        ev_set[vlm_pkg::EV_LOWER]      = sample_valid && !alarm_inhibit_r
                                         && sample_level < lower_alarm_level_r;
        ev_set[vlm_pkg::EV_DETACH]     = sample_valid && !source_role_r && detach_cond && !detach_prev_r;
        ev_set[vlm_pkg::EV_DRAIN_DONE] = drain_done;
    end

    always_comb
    begin
        ev_clr = '0;
        if (wr_byte && aw_idx_r == vlm_pkg::IDX_INT_CLEAR)
            ev_clr = wdata_r[vlm_pkg::EV_W-1:0];
    end

    // A set in the clearing cycle wins so no event is lost
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            int_status_r <= '0;
        else
            int_status_r <= (int_status_r & ~ev_clr) | ev_set;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            irq              <= 1'b0;
            upper_alarm_flag <= 1'b0;
            lower_alarm_flag <= 1'b0;
        end
        else
        begin
            irq              <= |(((int_status_r & ~ev_clr) | ev_set) & int_enable_r);
            upper_alarm_flag <= int_status_r[vlm_pkg::EV_UPPER] && !ev_clr[vlm_pkg::EV_UPPER]
                                || ev_set[vlm_pkg::EV_UPPER];
            lower_alarm_flag <= int_status_r[vlm_pkg::EV_LOWER] && !ev_clr[vlm_pkg::EV_LOWER]
                                || ev_set[vlm_pkg::EV_LOWER];
        end
    end

    // Read side; narrow registers sit in the low bits
    function automatic logic [7:0] read_byte(input logic [9:0] idx);
        case (idx)
            vlm_pkg::IDX_READ_LO:    read_byte = read_lo_r;
            vlm_pkg::IDX_READ_HI:    read_byte = read_hi_r;
            vlm_pkg::IDX_DETACH_LO:  read_byte = sink_detach_level_r[7:0];
            vlm_pkg::IDX_DETACH_HI:  read_byte = {6'h00, sink_detach_level_r[9:8]};
            vlm_pkg::IDX_STOP_LO:    read_byte = drain_stop_level_r[7:0];
            vlm_pkg::IDX_STOP_HI:    read_byte = {6'h00, drain_stop_level_r[9:8]};
            vlm_pkg::IDX_UPPER_LO:   read_byte = upper_alarm_level_r[7:0];
            vlm_pkg::IDX_UPPER_HI:   read_byte = {6'h00, upper_alarm_level_r[9:8]};
            vlm_pkg::IDX_LOWER_LO:   read_byte = lower_alarm_level_r[7:0];
            vlm_pkg::IDX_LOWER_HI:   read_byte = {6'h00, lower_alarm_level_r[9:8]};
            vlm_pkg::IDX_CTRL:       read_byte = {5'h00, source_role_r, alarm_inhibit_r, auto_drain_r};
            vlm_pkg::IDX_STATE:      read_byte = {6'h00, detached_r, drain_en};
            vlm_pkg::IDX_INT_STATUS: read_byte = {4'h0, int_status_r};
            vlm_pkg::IDX_INT_ENABLE: read_byte = {4'h0, int_enable_r};
            default:                 read_byte = 8'h00;
        endcase
    endfunction

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= vlm_pkg::RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h00_0000, read_byte(s_axi_araddr[11:2])};
            s_axi_rresp   <= idx_mapped(s_axi_araddr[11:2]) ? vlm_pkg::RESP_OKAY : vlm_pkg::RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
        end
    end

endmodule // vlm_monitor

// File: hw/vlm_pkg.sv
// Constants for the supply-rail level monitor and drain control
package vlm_pkg;
    localparam int          LEVEL_W         = 10;
    localparam int          ADDR_W          = 12;
    localparam int          DATA_W          = 32;
    // Register indices; byte address is four times the index
    localparam logic [9:0]  IDX_READ_LO     = 10'h070;
    localparam logic [9:0]  IDX_READ_HI     = 10'h071;
    localparam logic [9:0]  IDX_DETACH_LO   = 10'h072;
    localparam logic [9:0]  IDX_DETACH_HI   = 10'h073;
    localparam logic [9:0]  IDX_STOP_LO     = 10'h074;
    localparam logic [9:0]  IDX_STOP_HI     = 10'h075;
    localparam logic [9:0]  IDX_UPPER_LO    = 10'h076;
    localparam logic [9:0]  IDX_UPPER_HI    = 10'h077;
    localparam logic [9:0]  IDX_LOWER_LO    = 10'h078;
    localparam logic [9:0]  IDX_LOWER_HI    = 10'h079;
    localparam logic [9:0]  IDX_CTRL        = 10'h07A;
    localparam logic [9:0]  IDX_STATE       = 10'h07B;
    localparam logic [9:0]  IDX_INT_STATUS  = 10'h07C;
    localparam logic [9:0]  IDX_INT_CLEAR   = 10'h07D;
    localparam logic [9:0]  IDX_INT_ENABLE  = 10'h07E;
    // Field positions
    localparam int          HI_LEVEL_LSB    = 0;
    localparam int          HI_SCALE_LSB    = 2;
    localparam int          CTRL_AUTO_DRAIN = 0;
    localparam int          CTRL_INHIBIT    = 1;
    localparam int          CTRL_SOURCE     = 2;
    localparam int          CTRL_DRAIN_GO   = 3;
    localparam int          EV_UPPER        = 0;
    localparam int          EV_LOWER        = 1;
    localparam int          EV_DETACH       = 2;
    localparam int          EV_DRAIN_DONE   = 3;
    localparam int          EV_W            = 4;
    // Reset values and response codes
    localparam logic [7:0]  REG_RESET       = 8'h00;
    localparam logic [9:0]  LEVEL_RESET     = 10'h000;
    localparam logic [1:0]  RESP_OKAY       = 2'h0;
    localparam logic [1:0]  RESP_SLVERR     = 2'h2;
    // Level scaling and drain states
    localparam int          LSB_MV          = 25;
    localparam int          SAFE0_MV        = 800;
    localparam logic [9:0]  SAFE0_LEVEL     = 10'(SAFE0_MV / LSB_MV);
    typedef enum logic [1:0] {
        VLM_IDLE,
        VLM_DRAIN_SINK,
        VLM_DRAIN_SOURCE
    } vlm_drain_t;
endpackage

// File: tb/vlm_monitor_props.sv
// Port checker for the rail level monitor
`timescale 1ns/10ps
module vlm_monitor_props #(
    parameter int LEVEL_W = 10
) (
    input wire logic               aclk,
    input wire logic               aresetn,
    input wire logic               s_axi_awvalid,
    input wire logic               s_axi_awready,
    input wire logic               s_axi_wvalid,
    input wire logic               s_axi_wready,
    input wire logic [1:0]         s_axi_bresp,
    input wire logic               s_axi_bvalid,
    input wire logic               s_axi_bready,
    input wire logic               s_axi_arvalid,
    input wire logic               s_axi_arready,
    input wire logic [31:0]        s_axi_rdata,
    input wire logic               s_axi_rvalid,
    input wire logic               s_axi_rready,
    input wire logic               sample_valid,
    input wire logic [LEVEL_W-1:0] sample_level,
    input wire logic               drain_en,
    input wire logic               upper_alarm_flag,
    input wire logic               lower_alarm_flag
);
    default clocking dc @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
        else $error("write not answered");
    upper_cause_a: assert property ($rose(upper_alarm_flag) |-> $past(sample_valid))
        else $error("upper flag rose without a sample");
    lower_cause_a: assert property ($rose(lower_alarm_flag) |-> $past(sample_valid))
        else $error("lower flag rose without a sample");
    drain_floor_a: assert property (drain_en && sample_valid && sample_level <= vlm_pkg::SAFE0_LEVEL |=> !drain_en)
        else $error("drain ran past safe zero");
    drain_sync_a: assert property ($fell(drain_en) |-> $past(sample_valid))
        else $error("drain ended without a sample");

    cover property ($rose(upper_alarm_flag));
    cover property ($rose(lower_alarm_flag));
    cover property ($fell(drain_en));
endmodule // vlm_monitor_props

bind vlm_monitor vlm_monitor_props #(.LEVEL_W(LEVEL_W)) props_i (.*);

// File: tb/vlm_adc_model.sv
// Converter front end model: one registered sample per request
`timescale 1ns/10ps
module vlm_adc_model (
    input  wire logic       aclk,
    input  wire logic       go,
    input  wire logic [9:0] level,
    input  wire logic [1:0] scale,
    output logic            sample_valid = 1'b0,
    output logic [9:0]      sample_level = 10'h000,
    output logic [1:0]      sample_scale = 2'h0
);
    // Lines toggle between samples so stale data never looks valid
    always_ff @(posedge aclk)
    begin
        sample_valid <= go;
        sample_level <= go ? level : ~sample_level;
        sample_scale <= go ? scale : ~sample_scale;
    end
endmodule // vlm_adc_model

// File: tb/vlm_monitor_test.sv
// Self-checking bench for the rail level monitor
`timescale 1ns/10ps
module vlm_monitor_test;
    localparam logic [1:0] OK  = vlm_pkg::RESP_OKAY;
    localparam logic [1:0] ERR = vlm_pkg::RESP_SLVERR;
    logic        aclk, aresetn, adc_go;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, adc_scale, sample_scale;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic        sample_valid, supply_present_flag, drain_en, upper_alarm_flag, lower_alarm_flag, irq;
    logic [9:0]  sample_level, adc_level;
    int          errors, checked;

    vlm_monitor uut (.*);
    vlm_adc_model adc (.aclk, .go(adc_go), .level(adc_level), .scale(adc_scale), .sample_valid, .sample_level,
        .sample_scale);

    function automatic logic [7:0] reading_hi(input logic [9:0] l, input logic [1:0] s);
        return {4'h0, s, l[9:8]};
    endfunction

    // Port manager view: rail in mV from reading and scale code
    function automatic int rail_mv(input logic [9:0] l, input logic [1:0] s);
        return (l * vlm_pkg::LSB_MV) << s;
    endfunction

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp)
        begin
            errors++;
            $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask

    task automatic wr(input logic [9:0] i, input logic [7:0] d, input logic [1:0] er);
        logic a;
        logic w;
        a = 1'b1;
        w = 1'b1;
        s_axi_awaddr <= {i, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (a || w)
        begin
            @(posedge aclk);
            a = a && !s_axi_awready;
            w = w && !s_axi_wready;
            s_axi_awvalid <= a;
            s_axi_wvalid <= w;
        end
        // Ready raised late so the held response gets exercised
        while (!s_axi_bvalid)
            @(posedge aclk);
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        check("write response", {30'h0, s_axi_bresp}, {30'h0, er});
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [9:0] i, input logic [7:0] ed, input logic [1:0] er, input string nm);
        s_axi_araddr <= {i, 2'h0};
        s_axi_arvalid <= 1'b1;
        do
            @(posedge aclk);
        while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid)
            @(posedge aclk);
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        check(nm, {s_axi_rresp, s_axi_rdata[29:0]}, {er, 22'h0, ed});
        s_axi_rready <= 1'b0;
    endtask

    task automatic wl(input logic [9:0] i, input logic [9:0] v);
        wr(i, v[7:0], OK);
        wr(10'(i + 1), {6'h00, v[9:8]}, OK);
    endtask

    task automatic smp(input logic [9:0] l, input logic p);
        adc_go <= 1'b1;
        adc_level <= l;
        supply_present_flag <= p;
        @(posedge aclk);
        adc_go <= 1'b0;
        repeat (3)
            @(posedge aclk);
    endtask

    task automatic outs(input logic [3:0] e);
        check("irq lower upper drain", {28'h0, irq, lower_alarm_flag, upper_alarm_flag, drain_en}, {28'h0, e});
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        aclk = 1'b0;
        forever
            #10 aclk = ~aclk;
    end

    initial
    begin
        repeat (20000)
            @(posedge aclk);
        errors++;
        summarize();
    end

    initial
    begin
        logic [9:0] v;
        logic [1:0] s;
        logic [7:0] lo;
        errors = 0;
        checked = 0;
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, adc_go} = 7'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, adc_level, adc_scale} = 68'h0;
        s_axi_wstrb = 4'hF;
        supply_present_flag = 1'b1;
        void'($urandom(13962));
        repeat (3)
            @(posedge aclk);
        aresetn <= 1'b1;
        for (int k = 0; k < 10; k++)
            rd(10'(vlm_pkg::IDX_READ_LO + k), 8'h00, OK, "reset value");
        outs(4'h0);
        $display("reset test done");
        repeat (4)
        begin
            v = 10'($urandom_range(1023));
            s = 2'($urandom_range(2));
            adc_scale <= s;
            smp(v, 1'b1);
            rd(vlm_pkg::IDX_READ_LO, v[7:0], OK, "reading low");
            lo = s_axi_rdata[7:0];
            rd(vlm_pkg::IDX_READ_HI, reading_hi(v, s), OK, "reading high");
            check("rail voltage", rail_mv({s_axi_rdata[1:0], lo}, s_axi_rdata[3:2]), rail_mv(v, s));
        end
        $display("reading test done");
        for (int k = 0; k < 4; k++)
        begin
            v = 10'($urandom_range(1023));
            wr(10'(vlm_pkg::IDX_DETACH_LO + 2 * k), v[7:0], OK);
            wr(10'(vlm_pkg::IDX_DETACH_HI + 2 * k), {6'h3F, v[9:8]}, OK);
            rd(10'(vlm_pkg::IDX_DETACH_LO + 2 * k), v[7:0], OK, "level low");
            rd(10'(vlm_pkg::IDX_DETACH_HI + 2 * k), {6'h00, v[9:8]}, OK, "level high");
        end
        wr(vlm_pkg::IDX_READ_HI, 8'hFF, ERR);
        rd(10'h3FF, 8'h00, ERR, "unmapped");
        $display("level test done");
        wl(vlm_pkg::IDX_UPPER_LO, 10'h1F4);
        s_axi_wstrb <= 4'h0;
        wr(vlm_pkg::IDX_UPPER_LO, 8'h00, OK);
        s_axi_wstrb <= 4'hF;
        rd(vlm_pkg::IDX_UPPER_LO, 8'hF4, OK, "masked write");
        wl(vlm_pkg::IDX_LOWER_LO, 10'h064);
        wr(vlm_pkg::IDX_INT_CLEAR, 8'h0F, OK);
        wr(vlm_pkg::IDX_INT_ENABLE, 8'h03, OK);
        smp(10'h1F5, 1'b1);
        outs(4'hA);
        wr(vlm_pkg::IDX_INT_CLEAR, 8'h01, OK);
        smp(10'h1F4, 1'b1);
        outs(4'h0);
        smp(10'h063, 1'b1);
        outs(4'hC);
        wr(vlm_pkg::IDX_INT_CLEAR, 8'h02, OK);
        wr(vlm_pkg::IDX_CTRL, 8'h02, OK);
        smp(10'h258, 1'b1);
        smp(10'h00A, 1'b1);
        outs(4'h0);
        wr(vlm_pkg::IDX_INT_ENABLE, 8'h00, OK);
        wr(vlm_pkg::IDX_CTRL, 8'h00, OK);
        smp(10'h258, 1'b1);
        outs(4'h2);
        wl(vlm_pkg::IDX_UPPER_LO, 10'h3FF);
        wl(vlm_pkg::IDX_LOWER_LO, 10'h000);
        wr(vlm_pkg::IDX_INT_CLEAR, 8'h0F, OK);
        wr(vlm_pkg::IDX_INT_ENABLE, 8'h03, OK);
        outs(4'h0);
        $display("alarm test done");
        wl(vlm_pkg::IDX_DETACH_LO, 10'h000);
        wl(vlm_pkg::IDX_STOP_LO, 10'h064);
        wr(vlm_pkg::IDX_CTRL, 8'h01, OK);
        smp(10'h258, 1'b1);
        smp(10'h258, 1'b0);
        outs(4'h1);
        rd(vlm_pkg::IDX_STATE, 8'h03, OK, "drain state");
        rd(vlm_pkg::IDX_INT_STATUS, 8'h04, OK, "event status");
        smp(10'h021, 1'b0);
        outs(4'h1);
        smp(10'h020, 1'b0);
        outs(4'h0);
        wl(vlm_pkg::IDX_DETACH_LO, 10'h190);
        smp(10'h258, 1'b1);
        smp(10'h18F, 1'b1);
        outs(4'h1);
        smp(10'h020, 1'b1);
        outs(4'h0);
        $display("sink test done");
        wr(vlm_pkg::IDX_CTRL, 8'h04, OK);
        wr(vlm_pkg::IDX_CTRL, 8'h0C, OK);
        smp(10'h065, 1'b1);
        outs(4'h1);
        smp(10'h064, 1'b1);
        outs(4'h0);
        wl(vlm_pkg::IDX_STOP_LO, 10'h000);
        wr(vlm_pkg::IDX_CTRL, 8'h0C, OK);
        smp(10'h021, 1'b1);
        outs(4'h1);
        smp(10'h020, 1'b1);
        outs(4'h0);
        $display("source test done");
        summarize();
    end
endmodule // vlm_monitor_test
